// ---- logic/nfc_host.sv ----
// host-side nand flash pin sequencer: commands, addresses, data, busy wait
`timescale 1ns/1ps
`include "nfc_cfg.svh"
module nfc_host #(
	parameter int         WE_CYC  = `NFC_WE_CYC,
	parameter int         RE_CYC  = `NFC_RE_CYC,
	parameter int         WB_CYC  = `NFC_WB_CYC,
	parameter logic       PROTECT = 1'b0
) (
	input  wire logic                   clock,
	input  wire logic                   nrst,
	input  wire logic                   supply_ok,
	input  wire logic                   req_valid,
	input  wire nfc_pkg::nfc_op_t       req_op,
	input  wire logic [`NFC_COL_W-1:0]  req_col,
	input  wire logic [`NFC_ROW_W-1:0]  req_row,
	input  wire logic [`NFC_LEN_W-1:0]  req_len,
	output logic                        req_ready,
	output logic                        done,
	input  wire logic                   wr_valid,
	input  wire logic [7:0]             wr_data,
	output logic                        wr_ready,
	output logic                        rd_valid,
	output logic [7:0]                  rd_data,
	output logic                        nand_ce_n,
	output logic                        nand_cle,
	output logic                        nand_ale,
	output logic                        nand_we_n,
	output logic                        nand_re_n,
	output logic                        nand_wp_n,
	output logic                        power_on_protect_enable,
	output logic [7:0]                  nand_dq_o,
	output logic                        nand_dq_oe,
	input  wire logic [7:0]             nand_dq_i,
	input  wire logic                   nand_rb_n
);
	import nfc_pkg::*;

	nfc_state_t              state_ff;
	nfc_op_t                 op_ff;
	logic [5:0]              ph_ff;
	logic [2:0]              idx_ff;
	logic [`NFC_LEN_W-1:0]   cnt_ff;
	logic [`NFC_COL_W-1:0]   col_ff;
	logic [`NFC_ROW_W-1:0]   row_ff;
	logic [7:0]              wbuf_ff;
	logic [7:0]              dq_s;
	logic                    rb_s;
	logic                    sup_s;
	logic [7:0]              cur_byte;
	logic                    byte_st;
	logic                    byte_end;
	logic                    wr_take;

	nfc_sync #(.W(10)) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.d     ({supply_ok, nand_rb_n, nand_dq_i}),
		.q     ({sup_s, rb_s, dq_s})
	);

	localparam logic [5:0] WE_END = 6'(2 * WE_CYC);
	localparam logic [5:0] WE_LO  = 6'(WE_CYC);
	localparam logic [5:0] RE_LO  = 6'(RE_CYC);
	localparam logic [5:0] RE_SMP = 6'(RE_CYC + 2);
	localparam logic [5:0] RE_END = 6'(2 * RE_CYC);
	localparam logic [5:0] WB_END = 6'(WB_CYC);

	// address byte order, two column then three row
	function automatic logic [7:0] addr_byte(input logic [2:0] i,
			input logic [`NFC_COL_W-1:0] c, input logic [`NFC_ROW_W-1:0] r);
		unique case (i)
			3'h0:    addr_byte = c[7:0];
			3'h1:    addr_byte = {3'h0, c[12:8]};
			3'h2:    addr_byte = r[7:0];
			3'h3:    addr_byte = r[15:8];
			default: addr_byte = {5'h0, r[18:16]};
		endcase
	endfunction

	assign byte_st  = state_ff inside {st_cmd1, st_addr, st_wdata, st_cmd2};
	assign wr_take  = wr_ready && wr_valid;
	assign byte_end = byte_st && ph_ff == WE_END;

	// command, address and data share the one bus
	always_comb begin
		cur_byte = 8'h00;
		unique case (state_ff)
			st_cmd1: begin
				unique case (op_ff)
					op_reset:   cur_byte = `NFC_CMD_RESET;
					op_read:    cur_byte = `NFC_CMD_READ1;
					op_program: cur_byte = `NFC_CMD_PROG1;
					op_erase:   cur_byte = `NFC_CMD_ERASE1;
					default:    cur_byte = `NFC_CMD_STATUS;
				endcase
			end
			st_cmd2: begin
				unique case (op_ff)
					op_read:    cur_byte = `NFC_CMD_READ2;
					op_program: cur_byte = `NFC_CMD_PROG2;
					default:    cur_byte = `NFC_CMD_ERASE2;
				endcase
			end
			st_addr:  cur_byte = addr_byte(idx_ff, col_ff, row_ff);
			st_wdata: cur_byte = wbuf_ff;
			default:  cur_byte = 8'h00;
		endcase
	end

	// byte phase: 0 setup, 1..W strobe low, W+1..2W strobe high
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ph_ff <= 6'h00;
		end else if (state_ff == st_wdata && ph_ff == 6'h00) begin
			ph_ff <= wr_take ? 6'h01 : 6'h00;
		end else if (byte_end || (state_ff == st_rdata && ph_ff == RE_END)
				|| (state_ff == st_wb && ph_ff == WB_END)) begin
			ph_ff <= 6'h00;
		end else if (byte_st || state_ff inside {st_rdata, st_wb}) begin
			ph_ff <= ph_ff + 6'h01;
		end else begin
			ph_ff <= 6'h00;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_ff <= st_por;
			op_ff    <= op_reset;
			idx_ff   <= 3'h0;
			cnt_ff   <= '0;
			col_ff   <= '0;
			row_ff   <= '0;
		end else begin
			unique case (state_ff)
				// reset goes out first, once supply is good
				st_por: if (sup_s) begin
					op_ff    <= op_reset;
					state_ff <= st_cmd1;
				end
				// new command only while the device is ready
				st_idle: if (req_valid && req_ready) begin
					op_ff    <= req_op;
					col_ff   <= req_col;
					row_ff   <= req_row;
					cnt_ff   <= (req_op == op_status) ? `NFC_LEN_W'(1) : req_len;
					state_ff <= st_cmd1;
				end
				st_cmd1: if (byte_end) begin
					unique case (op_ff)
						op_reset:  state_ff <= st_wb;
						op_status: state_ff <= st_rdata;
						op_erase: begin
							idx_ff   <= `NFC_ROW_FIRST;
							state_ff <= st_addr;
						end
						default: begin
							idx_ff   <= 3'h0;
							state_ff <= st_addr;
						end
					endcase
				end
				st_addr: if (byte_end) begin
					idx_ff <= idx_ff + 3'h1;
					if (idx_ff == `NFC_ADDR_LAST)
						state_ff <= (op_ff == op_program) ? st_wdata : st_cmd2;
				end
				st_wdata: if (byte_end) begin
					cnt_ff <= cnt_ff - `NFC_LEN_W'(1);
					if (cnt_ff <= `NFC_LEN_W'(1))
						state_ff <= st_cmd2;
				end
				st_cmd2: if (byte_end) begin
					state_ff <= st_wb;
				end
				st_wb: if (ph_ff == WB_END) begin
					state_ff <= st_busy;
				end
				// the array time is covered by polling ready
				st_busy: if (rb_s) begin
					state_ff <= (op_ff == op_read) ? st_rdata : st_done;
				end
				st_rdata: if (ph_ff == RE_END) begin
					cnt_ff <= cnt_ff - `NFC_LEN_W'(1);
					if (cnt_ff <= `NFC_LEN_W'(1))
						state_ff <= st_done;
				end
				st_done: state_ff <= st_idle;
			endcase
		end
	end

	// write data: one byte taken per strobe cycle, stalls while wr_valid is low
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			wr_ready <= 1'b0;
			wbuf_ff  <= 8'h00;
		end else begin
			wr_ready <= state_ff == st_wdata && ph_ff == 6'h00 && !wr_take;
			if (wr_take)
				wbuf_ff <= wr_data;
		end
	end

	// pin drive, one cycle behind the sequencer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			nand_ce_n  <= 1'b1;
			nand_cle   <= 1'b0;
			nand_ale   <= 1'b0;
			nand_we_n  <= 1'b1;
			nand_re_n  <= 1'b1;
			nand_wp_n  <= 1'b0;
			nand_dq_o  <= 8'h00;
			nand_dq_oe <= 1'b0;
			power_on_protect_enable <= 1'b0;
		end else begin
			// select only while a sequence runs
			nand_ce_n <= state_ff inside {st_por, st_idle, st_done};
			// command latch enable for command bytes
			nand_cle  <= state_ff inside {st_cmd1, st_cmd2};
			// address latch enable for address bytes
			nand_ale  <= state_ff == st_addr;
			// rising write strobe ends each byte
			nand_we_n <= !(byte_st && ph_ff >= 6'h01 && ph_ff <= WE_LO);
			// one read strobe fall per byte fetched
			nand_re_n <= !(state_ff == st_rdata && ph_ff >= 6'h01 && ph_ff <= RE_LO);
			// release write protect only for program and erase
			nand_wp_n <= op_ff inside {op_program, op_erase}
				&& !(state_ff inside {st_por, st_idle});
			// host drives the bus only for its own bytes
			nand_dq_oe <= byte_st;
			// a data byte reaches the bus one cycle before its write strobe falls
			nand_dq_o  <= wr_take ? wr_data : cur_byte;
			// held low unless protection is wanted
			power_on_protect_enable <= PROTECT;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			req_ready <= 1'b0;
			done      <= 1'b0;
			rd_valid  <= 1'b0;
			rd_data   <= 8'h00;
		end else begin
			// ready needs supply and a released busy line
			req_ready <= state_ff == st_idle && rb_s && sup_s && !(req_valid && req_ready);
			done      <= state_ff == st_done;
			rd_valid  <= state_ff == st_rdata && ph_ff == RE_SMP;
			if (state_ff == st_rdata && ph_ff == RE_SMP)
				rd_data <= dq_s;
		end
	end

	logic any_cmd_ff;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			any_cmd_ff <= 1'b0;
		else if (nand_cle && !nand_we_n)
			any_cmd_ff <= 1'b1;
	end

	a_latch_excl: assert property (@(posedge clock) disable iff (!nrst)
		!(nand_cle && nand_ale)) else $error("cle and ale both high");
	a_first_reset: assert property (@(posedge clock) disable iff (!nrst)
		(nand_cle && !nand_we_n && !any_cmd_ff) |-> nand_dq_o == 8'hff)
		else $error("first command is not reset");
	a_oe_selected: assert property (@(posedge clock) disable iff (!nrst)
		nand_dq_oe |-> !nand_ce_n) else $error("bus driven while deselected");
	a_strobe_desel: assert property (@(posedge clock) disable iff (!nrst)
		nand_ce_n |-> nand_we_n && nand_re_n) else $error("strobe while deselected");
	a_we_width: assert property (@(posedge clock) disable iff (!nrst)
		$fell(nand_we_n) |-> !nand_we_n[*4] ##1 nand_we_n)
		else $error("write strobe width wrong");
	a_dq_stable: assert property (@(posedge clock) disable iff (!nrst)
		(!nand_we_n || $rose(nand_we_n)) |-> $stable(nand_dq_o))
		else $error("bus changed around write strobe");
	a_wp_read: assert property (@(posedge clock) disable iff (!nrst)
		(op_ff inside {op_read, op_status, op_reset}) |-> !nand_wp_n)
		else $error("write protect released outside program or erase");
	a_busy_wait: assert property (@(posedge clock) disable iff (!nrst)
		(state_ff == st_idle && req_valid && req_ready) |-> $past(rb_s))
		else $error("command accepted while busy");
	a_rd_strobe: assert property (@(posedge clock) disable iff (!nrst)
		rd_valid |-> $past(!nand_re_n, 2)) else $error("sample without read strobe");
	a_done_pulse: assert property (@(posedge clock) disable iff (!nrst)
		done |=> !done ##1 nand_ce_n) else $error("done not a single pulse");

	c_reset_done: cover property (@(posedge clock) disable iff (!nrst)
		op_ff == op_reset && done);
	c_read_byte: cover property (@(posedge clock) disable iff (!nrst)
		op_ff == op_read && rd_valid);
	c_program: cover property (@(posedge clock) disable iff (!nrst)
		op_ff == op_program && done);
	c_erase: cover property (@(posedge clock) disable iff (!nrst)
		op_ff == op_erase && done);
endmodule

// ---- include/nfc_cfg.svh ----
// timing counts, command codes and geometry of the nand pin sequencer
// What this block does
// - cle high: wr strobe rise latches command
// - ale high: wr strobe rise latches address
// - every byte latched on write strobe rise
// - device answers only when selected, not busy
// - reset command first after power-on
// - one shared bus, latch enables distinguish
// - five address cycles, two column, three row; erase sends the three row only
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH
`define NFC_CLK_MHZ      200
`define NFC_WE_NS        20
`define NFC_RE_NS        30
`define NFC_WB_NS        100
`define NFC_WE_CYC       ((`NFC_WE_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_RE_CYC       ((`NFC_RE_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_WB_CYC       ((`NFC_WB_NS * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_READ_US    45
`define NFC_T_READ_MP_US 55
`define NFC_T_PROG_US    350
`define NFC_T_ERASE_MS   4
`define NFC_MAIN_BYTES   2048
`define NFC_SPARE_BYTES  128
`define NFC_PAGES_BLK    64
`define NFC_BLKS_PLANE   2048
`define NFC_COL_W        13
`define NFC_PAGE_W       6
`define NFC_BLK_W        13
`define NFC_ROW_W        19
`define NFC_LEN_W        12
`define NFC_ADDR_LAST    3'h4
`define NFC_ROW_FIRST    3'h2
`define NFC_CMD_RESET    8'hff
`define NFC_CMD_READ1    8'h00
`define NFC_CMD_READ2    8'h30
`define NFC_CMD_PROG1    8'h80
`define NFC_CMD_PROG2    8'h10
`define NFC_CMD_ERASE1   8'h60
`define NFC_CMD_ERASE2   8'hd0
`define NFC_CMD_STATUS   8'h70
`endif

// ---- include/nfc_pkg.sv ----
// types shared by the nand pin sequencer
package nfc_pkg;
	typedef enum logic [2:0] {
		op_reset,
		op_read,
		op_program,
		op_erase,
		op_status
	} nfc_op_t;
	typedef enum {
		st_por,
		st_idle,
		st_cmd1,
		st_addr,
		st_wdata,
		st_cmd2,
		st_wb,
		st_busy,
		st_rdata,
		st_done
	} nfc_state_t;
endpackage

// ---- logic/nfc_sync.sv ----
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module nfc_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// ---- bench/nfc_dev_model.sv ----
// behavioural nand die as seen from the host pins
`timescale 1ns/1ps
module nfc_dev_model #(
	parameter int         BUSY_NS = 200,
	parameter logic [7:0] STATUS  = 8'he0
) (
	input  wire logic       ce_n,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] dq_o,
	input  wire logic       dq_oe,
	output logic      [7:0] dq,
	output logic            rb_n
);
	logic [7:0]  mem [0:4095];
	logic [7:0]  ab [0:4];
	logic [7:0]  cmd, first_cmd, dout;
	logic [12:0] col;
	logic        busy, rd, smode;
	int          ai, ncmd, stray, clash, nerase;
	time         t_busy;
	initial begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i) ^ 8'h5a;
		{busy, rd, smode, dout, cmd} = '0;
		{ai, ncmd, stray, clash, nerase} = '0;
	end
	task automatic go_busy();
		busy = 1'b1;
		t_busy = $time;
		busy <= #(BUSY_NS) 1'b0;
	endtask
	assign rb_n = busy ? 1'b0 : 1'b1;
	// floating bus shows inverse of last byte
	assign dq = dq_oe ? dq_o : (rd && !ce_n) ? dout : ~dout;
	always @(posedge ce_n)
		rd = 1'b0;
	// write strobe latch
	// skip the strobe edge that the host's own reset makes
	always @(posedge we_n) if ($time > 10) begin
		if (ce_n)
			stray++;
		else if (cle) begin
			if (busy && dq != 8'h70 && dq != 8'hff)
				stray++;
			cmd = dq;
			ncmd++;
			if (ncmd == 1)
				first_cmd = dq;
			rd = (dq == 8'h70 || dq == 8'h30);
			smode = (dq == 8'h70);
			if (dq == 8'h60)
				ai = 2;
			if (dq == 8'h00 || dq == 8'h80)
				ai = 0;
			if (dq == 8'hd0 && wp_n)
				nerase++;
			if (dq == 8'h30 || dq == 8'h10 || dq == 8'hd0 || dq == 8'hff)
				go_busy();
		end else if (ale) begin
			ab[ai] = dq;
			if (ai == 1)
				col = {dq[4:0], ab[0]};
			ai++;
		end else if (cmd == 8'h80 && wp_n) begin
			mem[col[11:0]] = dq;
			col++;
		end
	end
	// next byte per read strobe fall
	always @(negedge re_n) if ($time > 10) begin
		if (ce_n || busy || dq_oe)
			stray++;
		else if (rd) begin
			dout = smode ? STATUS : mem[col[11:0]];
			if (!smode)
				col++;
		end
	end
	always @(posedge dq_oe)
		if (rd && !ce_n)
			clash++;
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the host nand pin sequencer
`timescale 1ns/1ps
`include "nfc_cfg.svh"
module tb;
	import nfc_pkg::*;
	logic                  clock, nrst, supply_ok, req_valid, wr_valid;
	nfc_op_t               req_op;
	logic [`NFC_COL_W-1:0] req_col;
	logic [`NFC_ROW_W-1:0] req_row;
	logic [`NFC_LEN_W-1:0] req_len;
	logic                  req_ready, done, wr_ready, rd_valid, ce_n, cle, ale;
	logic                  we_n, re_n, wp_n, ppe, dq_oe, rb_n;
	logic [7:0]            wr_data, rd_data, dq_o, dq;
	logic [7:0]            wbuf [0:3];
	logic [7:0]            rq [$];
	int                    wi, n_mismatch, tests_run;
	time                   t0, td;
	nfc_host u_nfc_host (
		.clock(clock), .nrst(nrst), .supply_ok(supply_ok),
		.req_valid(req_valid), .req_op(req_op), .req_col(req_col),
		.req_row(req_row), .req_len(req_len), .req_ready(req_ready),
		.done(done), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
		.nand_re_n(re_n), .nand_wp_n(wp_n), .power_on_protect_enable(ppe),
		.nand_dq_o(dq_o), .nand_dq_oe(dq_oe), .nand_dq_i(dq), .nand_rb_n(rb_n)
	);
	nfc_dev_model u_nfc_dev_model (
		.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
		.wp_n(wp_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq(dq), .rb_n(rb_n)
	);
	assign wr_data = wbuf[wi[1:0]];
	always @(posedge clock)
		if (wr_valid && wr_ready)
			wi <= wi + 1;
	always @(negedge clock)
		if (rd_valid === 1'b1)
			rq.push_back(rd_data);
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic print_verdict();
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wait_done();
		int k;
		k = 0;
		while (done !== 1'b1 && k < 5000) begin
			@(negedge clock);
			k++;
		end
		td = $time;
		check(8'(k < 5000), 8'h01);
		repeat (2) @(negedge clock);
	endtask
	task automatic run(input nfc_op_t op, input int c, input int r, input int n);
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 5000) begin
			@(negedge clock);
			k++;
		end
		check(8'(k < 5000), 8'h01);
		req_op = op;
		req_col = c[`NFC_COL_W-1:0];
		req_row = r[`NFC_ROW_W-1:0];
		req_len = n[`NFC_LEN_W-1:0];
		req_valid = 1'b1;
		t0 = $time;
		rq = {};
		wi = 0;
		wr_valid = (op == op_program);
		@(negedge clock);
		req_valid = 1'b0;
		wait_done();
		wr_valid = 1'b0;
	endtask
	task automatic t_power_up();
		repeat (4) @(negedge clock);
		check(8'(ce_n), 8'h01);
		nrst = 1'b1;
		repeat (40) @(negedge clock);
		check(8'(u_nfc_dev_model.ncmd), 8'h00);
		check(8'(ce_n), 8'h01);
		supply_ok = 1'b1;
		wait_done();
		check(u_nfc_dev_model.first_cmd, `NFC_CMD_RESET);
		check(8'(ppe), 8'h00);
		check(8'(wp_n), 8'h00);
		check(8'(dq_oe), 8'h00);
	endtask
	task automatic t_prog_read();
		int r;
		r = {13'h1235, 6'h2a};
		wbuf = '{8'h11, 8'h22, 8'h33, 8'h44};
		run(op_program, 261, r, 4);
		check(8'(wi), 8'h04);
		check(u_nfc_dev_model.ab[0], 8'h05);
		check(u_nfc_dev_model.ab[1], 8'h01);
		check(u_nfc_dev_model.ab[2], r[7:0]);
		check(u_nfc_dev_model.ab[3], r[15:8]);
		check(u_nfc_dev_model.ab[4], {5'h0, r[18:16]});
		check(8'(td - u_nfc_dev_model.t_busy >= 200), 8'h01);
		run(op_read, 261, r, 4);
		check(8'(rq.size()), 8'h04);
		for (int i = 0; i < 4; i++)
			check(rq[i], wbuf[i]);
	endtask
	task automatic t_erase();
		int r;
		r = {13'h0a53, 6'h11};
		run(op_erase, 0, r, 1);
		check(8'(u_nfc_dev_model.nerase), 8'h01);
		check(u_nfc_dev_model.ab[2], r[7:0]);
		check(8'(td - u_nfc_dev_model.t_busy >= 200), 8'h01);
	endtask
	task automatic t_status();
		run(op_status, 0, 0, 1);
		check(8'(rq.size()), 8'h01);
		check(rq[0], 8'he0);
	endtask
	task automatic t_spare_end();
		run(op_read, 2175, 0, 1);
		check(rq[0], 8'(2175) ^ 8'h5a);
		run(op_read, 260, {13'h1235, 6'h2a}, 3);
		check(rq[0], 8'(260) ^ 8'h5a);
		check(rq[1], 8'h11);
		check(rq[2], 8'h22);
	endtask
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		nrst = 1'b0;
		supply_ok = 1'b0;
		req_valid = 1'b0;
		wr_valid = 1'b0;
		req_op = op_reset;
		req_col = '0;
		req_row = '0;
		req_len = '0;
		wi = 0;
		n_mismatch = 0;
		tests_run = 0;
		t_power_up();
		t_prog_read();
		t_erase();
		t_status();
		t_spare_end();
		check(8'(u_nfc_dev_model.stray), 8'h00);
		check(8'(u_nfc_dev_model.clash), 8'h00);
		print_verdict();
	end
endmodule
